// ---- logic/cold_load_consts.vh ----
// Constants for the cold load pickup block: register map, field positions,
// reset values and time-base figures. Definitions only.
`ifndef COLD_LOAD_CONSTS_VH
`define COLD_LOAD_CONSTS_VH

// Register offsets (byte addresses)
`define CLP_ADDR_CTRL 8'h00
`define CLP_ADDR_LOADOFF 8'h04
`define CLP_ADDR_SETTLE 8'h08
`define CLP_ADDR_MAXBLK 8'h0C
`define CLP_ADDR_STATUS 8'h10
`define CLP_ADDR_IRQ_STAT 8'h14
`define CLP_ADDR_IRQ_MASK 8'h18

// Control register fields
`define CLP_CTRL_MODE_LO 0
`define CLP_CTRL_MODE_HI 1
`define CLP_CTRL_ON 2
`define CLP_CTRL_EXT_USE 3
`define CLP_CTRL_INT_USE 4

// Detection modes
`define CLP_MODE_BREAKER 2'h0
`define CLP_MODE_UNDER 2'h1
`define CLP_MODE_AND 2'h2
`define CLP_MODE_OR 2'h3

// Interrupt status bits
`define CLP_EV_ENABLE_RISE 0
`define CLP_EV_ENABLE_FALL 1
`define CLP_EV_MAXBLK_EXP 2
`define CLP_EV_BLOCKED 3
`define CLP_EV_WIDTH 4

// Reset values
`define CLP_CTRL_RESET 5'h04
`define CLP_LOADOFF_RESET 16'h000A
`define CLP_SETTLE_RESET 16'h0005
`define CLP_MAXBLK_RESET 16'h0032
`define CLP_MASK_RESET 4'h0

// Time base
`define CLP_CLOCK_PERIOD_NS 10
`define CLP_TICK_PERIOD_NS 1000000
`define CLP_TICK_CYCLES (`CLP_TICK_PERIOD_NS / `CLP_CLOCK_PERIOD_NS)

`endif

// ---- logic/cold_load_tick.v ----
// Time-base tick generator: one-cycle pulse every TICK_CYCLES clocks.
// Assumes a single free-running clock and asynchronous active-low reset.
`timescale 1ns/1ps
module cold_load_tick #(
    parameter [31:0] TICK_CYCLES = 32'h0001_86A0
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_n_in,
    // Tick
    output reg tick_out
);
    reg [31:0] count_reg;

    always @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count_reg <= 32'h0000_0000;
            tick_out <= 1'b0;
        end
        else if (count_reg >= TICK_CYCLES - 32'h0000_0001)
        begin
            count_reg <= 32'h0000_0000;
            tick_out <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + 32'h0000_0001;
            tick_out <= 1'b0;
        end
    end
endmodule // cold_load_tick

// ---- logic/cold_load_timer.v ----
// Tick-counting timer against a register-held duration.
// Assumes tick_in is a one-cycle pulse; clear_in holds the timer at zero.
`timescale 1ns/1ps
module cold_load_timer #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_n_in,
    // Control
    input wire clear_in,
    input wire tick_in,
    input wire [WIDTH-1:0] duration_in,
    // Result
    output reg expired_out
);
    reg [WIDTH-1:0] count_reg;

    always @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count_reg <= {WIDTH{1'b0}};
            expired_out <= 1'b0;
        end
        else if (clear_in)
        begin
            count_reg <= {WIDTH{1'b0}};
            expired_out <= 1'b0;
        end
        else if (tick_in && !expired_out)
        begin
            if (count_reg + 1'b1 >= duration_in)
                expired_out <= 1'b1;
            else
                count_reg <= count_reg + 1'b1;
        end
    end
endmodule // cold_load_timer

// ---- logic/cold_load_pickup.v ----
// Cold load pickup: detects warm-to-cold load, raises an enable after a
// load-off delay, ends it through the inrush/settle path or max-block timer.
// Assumes comparator and breaker inputs synchronous to clock_in.
//
// Summary of operation
// - Four detection modes: breaker, undercurrent, AND, OR
// - Cold transition starts the load-off delay timer
// - Load-off expiry asserts the cold load enable
// - Cold condition ending starts the inrush detector
// - Inrush present when current exceeds inrush threshold
// - Inrush finished when current falls to 90 percent
// - Settle timer starts once inrush has diminished
// - Enable ends via inrush path after settle expiry
// - Max-block timer parallel to inrush detector ends enable
// - Max-block stops after current low for settle time
// - Selectable external or internal block inhibits function
// - Running auto-reclose blocks the function automatically
// - Only an enable signal, never a trip
// - Breaker open, no current: enable and undercurrent shown
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "cold_load_consts.vh"
module cold_load_pickup #(
    parameter [31:0] TICK_CYCLES = `CLP_TICK_CYCLES,
    parameter TIMER_WIDTH = 16
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_n_in,
    // Register port
    input wire [7:0] addr_in,
    input wire [31:0] wr_data_in,
    input wire wr_strobe_in,
    input wire rd_strobe_in,
    output reg [31:0] rd_data_out,
    // Measurement and breaker
    input wire breaker_position_in,
    input wire undercurrent_in,
    input wire above_inrush_in,
    input wire below_inrush_90_in,
    // Blocking
    input wire ext_block_in,
    input wire int_block_in,
    input wire auto_reclose_running_in,
    // Status and interrupt
    output reg cold_load_enable_out,
    output reg undercurrent_indication_out,
    output reg inrush_present_out,
    output reg irq_out
);
    localparam [3:0] ST_WARM = 4'b0001;
    localparam [3:0] ST_LOADOFF = 4'b0010;
    localparam [3:0] ST_COLD = 4'b0100;
    localparam [3:0] ST_RELEASE = 4'b1000;

    reg [4:0] ctrl_reg;
    reg [TIMER_WIDTH-1:0] loadoff_reg;
    reg [TIMER_WIDTH-1:0] settle_reg;
    reg [TIMER_WIDTH-1:0] maxblk_reg;
    reg [`CLP_EV_WIDTH-1:0] irq_stat_reg;
    reg [`CLP_EV_WIDTH-1:0] irq_stat_next;
    reg [`CLP_EV_WIDTH-1:0] irq_mask_reg;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg breaker_reg;
    reg under_reg;
    reg above_reg;
    reg below90_reg;
    reg blocked_reg;
    reg inrush_next;
    reg [31:0] rd_next;
    reg [`CLP_EV_WIDTH-1:0] events;
    wire tick;
    wire loadoff_exp;
    wire settle_exp;
    wire maxblk_exp;
    wire cold;
    wire blocked;
    wire enable_next;

    // Cold condition per selected mode
    function cold_detect;
        input [1:0] mode;
        input brk_open;
        input under;
        begin
            case (mode)
                `CLP_MODE_BREAKER: cold_detect = brk_open;
                `CLP_MODE_UNDER: cold_detect = under;
                `CLP_MODE_AND: cold_detect = brk_open & under;
                default: cold_detect = brk_open | under;
            endcase
        end
    endfunction

    cold_load_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) tick_gen (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .tick_out(tick)
    );

    // Comparator results latched on the tick only
    always @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            breaker_reg <= 1'b0;
            under_reg <= 1'b0;
            above_reg <= 1'b0;
            below90_reg <= 1'b0;
        end
        else if (tick)
        begin
            breaker_reg <= breaker_position_in;
            under_reg <= undercurrent_in;
            above_reg <= above_inrush_in;
            below90_reg <= below_inrush_90_in;
        end
    end

    assign cold = cold_detect(ctrl_reg[`CLP_CTRL_MODE_HI:`CLP_CTRL_MODE_LO], breaker_reg, under_reg);

    // Block sources; auto-reclose always blocks
    assign blocked = !ctrl_reg[`CLP_CTRL_ON]
        | (ctrl_reg[`CLP_CTRL_EXT_USE] & ext_block_in)
        | (ctrl_reg[`CLP_CTRL_INT_USE] & int_block_in)
        | auto_reclose_running_in;

    cold_load_timer #(
        .WIDTH(TIMER_WIDTH)
    ) loadoff_timer (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .clear_in(blocked | (state_reg != ST_LOADOFF)),
        .tick_in(tick),
        .duration_in(loadoff_reg),
        .expired_out(loadoff_exp)
    );

    cold_load_timer #(
        .WIDTH(TIMER_WIDTH)
    ) settle_timer (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .clear_in(blocked | (state_reg != ST_RELEASE) | !below90_reg | inrush_present_out),
        .tick_in(tick),
        .duration_in(settle_reg),
        .expired_out(settle_exp)
    );

    cold_load_timer #(
        .WIDTH(TIMER_WIDTH)
    ) maxblk_timer (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .clear_in(blocked | (state_reg != ST_RELEASE)),
        .tick_in(tick),
        .duration_in(maxblk_reg),
        .expired_out(maxblk_exp)
    );

    // Sequence control
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_WARM:
            begin
                if (cold)
                    state_next = ST_LOADOFF;
            end
            ST_LOADOFF:
            begin
                if (!cold)
                    state_next = ST_WARM;
                else if (loadoff_exp)
                    state_next = ST_COLD;
            end
            ST_COLD:
            begin
                if (!cold)
                    state_next = ST_RELEASE;
            end
            ST_RELEASE:
            begin
                if (cold)
                    state_next = ST_COLD;
                else if (settle_exp)
                    state_next = ST_WARM;
                else if (maxblk_exp)
                    state_next = ST_WARM;
            end
            default:
            begin
                state_next = ST_WARM;
            end
        endcase
        if (blocked)
            state_next = ST_WARM;
    end

    assign enable_next = (state_next == ST_COLD) | (state_next == ST_RELEASE);

    // Inrush detector with hysteresis
    always @*
    begin
        inrush_next = 1'b0;
        if (state_next == ST_RELEASE)
        begin
            if (above_reg)
                inrush_next = 1'b1;
            else if (below90_reg)
                inrush_next = 1'b0;
            else
                inrush_next = inrush_present_out;
        end
    end

    // Interrupt events
    always @*
    begin
        events = {`CLP_EV_WIDTH{1'b0}};
        events[`CLP_EV_ENABLE_RISE] = enable_next & !cold_load_enable_out;
        events[`CLP_EV_ENABLE_FALL] = !enable_next & cold_load_enable_out;
        events[`CLP_EV_MAXBLK_EXP] = (state_reg == ST_RELEASE) & maxblk_exp & !settle_exp & !cold & !blocked;
        events[`CLP_EV_BLOCKED] = blocked & !blocked_reg;
        irq_stat_next = irq_stat_reg;
        if (rd_strobe_in && addr_in == `CLP_ADDR_IRQ_STAT)
            irq_stat_next = {`CLP_EV_WIDTH{1'b0}};
        irq_stat_next = irq_stat_next | events;
    end

    // Register read mux
    always @*
    begin
        rd_next = 32'h0000_0000;
        case (addr_in)
            `CLP_ADDR_CTRL: rd_next[4:0] = ctrl_reg;
            `CLP_ADDR_LOADOFF: rd_next[TIMER_WIDTH-1:0] = loadoff_reg;
            `CLP_ADDR_SETTLE: rd_next[TIMER_WIDTH-1:0] = settle_reg;
            `CLP_ADDR_MAXBLK: rd_next[TIMER_WIDTH-1:0] = maxblk_reg;
            `CLP_ADDR_STATUS: rd_next[8:0] = {blocked_reg, inrush_present_out,
                undercurrent_indication_out, cold_load_enable_out, state_reg};
            `CLP_ADDR_IRQ_STAT: rd_next[`CLP_EV_WIDTH-1:0] = irq_stat_reg;
            `CLP_ADDR_IRQ_MASK: rd_next[`CLP_EV_WIDTH-1:0] = irq_mask_reg;
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // Register writes
    always @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_reg <= `CLP_CTRL_RESET;
            loadoff_reg <= `CLP_LOADOFF_RESET;
            settle_reg <= `CLP_SETTLE_RESET;
            maxblk_reg <= `CLP_MAXBLK_RESET;
            irq_mask_reg <= `CLP_MASK_RESET;
        end
        else if (wr_strobe_in)
        begin
            case (addr_in)
                `CLP_ADDR_CTRL: ctrl_reg <= wr_data_in[4:0];
                `CLP_ADDR_LOADOFF: loadoff_reg <= wr_data_in[TIMER_WIDTH-1:0];
                `CLP_ADDR_SETTLE: settle_reg <= wr_data_in[TIMER_WIDTH-1:0];
                `CLP_ADDR_MAXBLK: maxblk_reg <= wr_data_in[TIMER_WIDTH-1:0];
                `CLP_ADDR_IRQ_MASK: irq_mask_reg <= wr_data_in[`CLP_EV_WIDTH-1:0];
                default: irq_mask_reg <= irq_mask_reg;
            endcase
        end
    end

    // State and registered outputs; no trip output exists
    always @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= ST_WARM;
            blocked_reg <= 1'b0;
            cold_load_enable_out <= 1'b0;
            undercurrent_indication_out <= 1'b0;
            inrush_present_out <= 1'b0;
            irq_stat_reg <= {`CLP_EV_WIDTH{1'b0}};
            irq_out <= 1'b0;
            rd_data_out <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            blocked_reg <= blocked;
            cold_load_enable_out <= enable_next;
            undercurrent_indication_out <= under_reg;
            inrush_present_out <= inrush_next;
            irq_stat_reg <= irq_stat_next;
            irq_out <= |(irq_stat_next & irq_mask_reg);
            rd_data_out <= rd_strobe_in ? rd_next : 32'h0000_0000;
        end
    end
endmodule // cold_load_pickup

// ---- test/cold_load_chk.sv ----
// Port-level checker for the cold load pickup block.
// Assumes a time-base tick of at least four clocks.
`timescale 1ns/1ps
module cold_load_chk #(
    parameter [31:0] TICK_CYCLES = 32'h0000_0004
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_n_in,
    // Inputs watched
    input wire wr_strobe_in,
    input wire rd_strobe_in,
    input wire undercurrent_in,
    input wire above_inrush_in,
    input wire ext_block_in,
    input wire int_block_in,
    input wire auto_reclose_running_in,
    // Outputs watched
    input wire [31:0] rd_data_out,
    input wire cold_load_enable_out,
    input wire undercurrent_indication_out,
    input wire inrush_present_out,
    input wire irq_out
);
    wire en = cold_load_enable_out;
    wire any_blk = ext_block_in | int_block_in | auto_reclose_running_in | wr_strobe_in;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    AST_RD_IDLE: assert property (!$past(rd_strobe_in) |-> rd_data_out == 32'h0000_0000)
        else $error("read data outside its answer cycle");
    AST_AR_BLOCKS: assert property (auto_reclose_running_in [*2] |-> !en)
        else $error("enable high during auto reclose");
    AST_NO_RISE_AR: assert property ($rose(en) |-> !$past(auto_reclose_running_in))
        else $error("enable rose right after auto reclose");
    AST_UC_RISE: assert property ($rose(undercurrent_indication_out) |-> $past(undercurrent_in))
        else $error("undercurrent shown without low current");
    AST_UC_FALL: assert property ($fell(undercurrent_indication_out) |-> !$past(undercurrent_in) || $past(any_blk))
        else $error("undercurrent dropped while current low");
    AST_INRUSH_RISE: assert property ($rose(inrush_present_out) |-> $past(above_inrush_in) && en)
        else $error("inrush set without high current");
    AST_EN_MIN: assert property ($rose(en) ##0 (!any_blk) [*4] |-> en)
        else $error("enable ended too soon");
    AST_AR_NO_INRUSH: assert property (auto_reclose_running_in [*3] |-> !inrush_present_out)
        else $error("inrush detector runs while blocked");
    cover property ($rose(en));
    cover property ($fell(en));
    cover property ($rose(inrush_present_out));
    cover property ($rose(irq_out));
endmodule // cold_load_chk

bind cold_load_pickup cold_load_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .undercurrent_in(undercurrent_in),
    .above_inrush_in(above_inrush_in), .ext_block_in(ext_block_in), .int_block_in(int_block_in),
    .auto_reclose_running_in(auto_reclose_running_in), .rd_data_out(rd_data_out),
    .cold_load_enable_out(cold_load_enable_out), .undercurrent_indication_out(undercurrent_indication_out),
    .inrush_present_out(inrush_present_out), .irq_out(irq_out));

// ---- test/feeder_model.sv ----
// Feeder model: breaker position and current comparator bits.
// Assumes commands change just after a rising clock edge.
`timescale 1ns/1ps
module feeder_model (
    // Clock
    input wire clock_in,
    // Commands: level 0 none, 1 load, 2 near threshold, 3 inrush
    input wire brk_open_in,
    input wire [1:0] level_in,
    // Position and comparator bits
    output reg breaker_position_out = 1'b0,
    output reg undercurrent_out = 1'b0,
    output reg above_inrush_out = 1'b0,
    output reg below_inrush_90_out = 1'b1
);
    wire [1:0] cur = brk_open_in ? 2'h0 : level_in;
    always @(posedge clock_in)
    begin
        breaker_position_out <= brk_open_in;
        undercurrent_out <= (cur == 2'h0);
        above_inrush_out <= (cur == 2'h3);
        below_inrush_90_out <= (cur < 2'h2);
    end
endmodule // feeder_model

// ---- test/tb.sv ----
// Testbench for the cold load pickup block with a feeder model.
// Assumes the tick parameter shortened to four clocks.
`timescale 1ns/1ps
`include "cold_load_consts.vh"
module tb;
    localparam int T = 4;
    localparam int L = 3;
    localparam int S = 2;
    localparam int M = 20;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic brk = 1'b0;
    logic [1:0] lvl = 2'h1;
    logic ext = 1'b0;
    logic intb = 1'b0;
    logic ar = 1'b0;
    logic [4:0] c;
    logic [31:0] got;
    wire [31:0] rdata;
    wire bpos, uc, above, below, en, ucind, inr, irq;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n;
    logic [7:0] ra [6] = '{`CLP_ADDR_CTRL, `CLP_ADDR_LOADOFF, `CLP_ADDR_SETTLE, `CLP_ADDR_MAXBLK,
        `CLP_ADDR_IRQ_MASK, 8'h1C};
    logic [31:0] rv [6] = '{`CLP_CTRL_RESET, `CLP_LOADOFF_RESET, `CLP_SETTLE_RESET, `CLP_MAXBLK_RESET,
        `CLP_MASK_RESET, 32'h0000_0000};

    feeder_model far (.clock_in(clock_in), .brk_open_in(brk), .level_in(lvl), .breaker_position_out(bpos),
        .undercurrent_out(uc), .above_inrush_out(above), .below_inrush_90_out(below));
    cold_load_pickup #(.TICK_CYCLES(T)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr),
        .wr_data_in(wdata), .wr_strobe_in(wr), .rd_strobe_in(rd), .rd_data_out(rdata),
        .breaker_position_in(bpos), .undercurrent_in(uc), .above_inrush_in(above),
        .below_inrush_90_in(below), .ext_block_in(ext), .int_block_in(intb), .auto_reclose_running_in(ar),
        .cold_load_enable_out(en), .undercurrent_indication_out(ucind), .inrush_present_out(inr),
        .irq_out(irq));

    initial
    begin
        forever #5 clock_in = ~clock_in;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a);
        @(posedge clock_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        #1 got = rdata;
    endtask

    task automatic wait_en(input logic v, input int lim);
        n = 0;
        while (en !== v && n < lim)
        begin
            @(posedge clock_in);
            #1 n++;
        end
        if (en !== v)
        begin
            n_mismatch++;
            $display("unexpected at %0t: wait %h limit %h", $time, n, lim);
            complete_run();
        end
    endtask

    // Expected enable from mode, breaker, current level and blocks
    function automatic logic exp_en(input logic [4:0] m, input logic b, input logic [1:0] v,
        input logic e, input logic i);
        logic u;
        logic cold;
        u = b | (v == 2'h0);
        cold = (m[1:0] == `CLP_MODE_BREAKER) ? b : (m[1:0] == `CLP_MODE_UNDER) ? u :
            (m[1:0] == `CLP_MODE_AND) ? (b & u) : (b | u);
        exp_en = cold & ~(e & m[3]) & ~(i & m[4]);
    endfunction

    initial
    begin
        n = $urandom(32'hc2c0_0ed7);
        repeat (12) @(posedge clock_in);
        rst_n_in <= 1'b1;
        wreg(8'h1C, 32'hFFFF_FFFF);
        for (int k = 0; k < 6; k++)
        begin
            rreg(ra[k]);
            chk(got, rv[k]);
        end
        $display("test reset done");
        wreg(`CLP_ADDR_LOADOFF, L);
        wreg(`CLP_ADDR_SETTLE, S);
        wreg(`CLP_ADDR_MAXBLK, M);
        wreg(`CLP_ADDR_IRQ_MASK, 32'h0000_000F);
        rreg(`CLP_ADDR_LOADOFF);
        chk(got, L);
        brk <= 1'b1;
        lvl <= 2'h0;
        wait_en(1'b1, 40);
        chk(32'(n >= L * T && n <= (L + 1) * T + 6), 32'h0000_0001);
        chk({30'h0, ucind, en}, 32'h0000_0003);
        chk(32'(irq), 32'h0000_0001);
        rreg(`CLP_ADDR_IRQ_STAT);
        chk(got & 32'h0000_0001, 32'h0000_0001);
        repeat (2) @(posedge clock_in);
        #1 chk(32'(irq), 32'h0000_0000);
        $display("test pickup done");
        brk <= 1'b0;
        lvl <= 2'h3;
        repeat (3 * T) @(posedge clock_in);
        #1 chk({30'h0, inr, en}, 32'h0000_0003);
        lvl <= 2'h2;
        repeat (3 * T) @(posedge clock_in);
        #1 chk({30'h0, inr, en}, 32'h0000_0003);
        lvl <= 2'h1;
        wait_en(1'b0, 40);
        chk(32'(n >= S * T && n <= (S + 2) * T + 6), 32'h0000_0001);
        rreg(`CLP_ADDR_IRQ_STAT);
        chk(got & 32'h0000_0006, 32'h0000_0002);
        $display("test inrush done");
        brk <= 1'b1;
        lvl <= 2'h0;
        wait_en(1'b1, 40);
        brk <= 1'b0;
        lvl <= 2'h3;
        wait_en(1'b0, (M + 2) * T + 10);
        chk(32'(n >= M * T && n <= (M + 1) * T + 6), 32'h0000_0001);
        rreg(`CLP_ADDR_IRQ_STAT);
        chk(got & 32'h0000_0004, 32'h0000_0004);
        $display("test maxblock done");
        for (int k = 0; k < 12; k++)
        begin
            ar <= 1'b1;
            c = {2'($urandom), 1'b1, 2'(k)};
            wreg(`CLP_ADDR_CTRL, {27'h0, c});
            brk <= 1'($urandom);
            lvl <= 2'($urandom % 2);
            ext <= 1'($urandom);
            intb <= 1'($urandom);
            repeat (3) @(posedge clock_in);
            #1 chk(32'(en), 32'h0000_0000);
            ar <= 1'b0;
            repeat ((L + 3) * T) @(posedge clock_in);
            #1 chk(32'(en), 32'(exp_en(c, brk, lvl, ext, intb)));
        end
        $display("test modes done");
        complete_run();
    end
endmodule // tb
